// ===== design/acctd_pkg.sv
// constants for the accumulator transfer decode block
package acctd_pkg;

  // ----------------------------------------------------------------
  // opcode layout
  // ----------------------------------------------------------------
  localparam int          OPC_W        = 10;
  localparam int          NIB_W        = 4;
  localparam int          IMM_LSB      = 0;
  localparam int          PFX_LSB      = 4;
  localparam int          PFX_W        = 6;
  localparam int          ACC_BIT0     = 0;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [9:0]  OPC_WAKE3    = 10'h0_215;
  localparam logic [5:0]  PFX_STXOR    = 6'h2B;
  localparam logic [9:0]  OPC_CLKCTL   = 10'h0_216;
  localparam logic [9:0]  OPC_TMRBIT   = 10'h0_2AA;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_NIB      = 4'h0;
  localparam logic        RST_BIT      = 1'b0;

  // ----------------------------------------------------------------
  // instruction kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACCTD_NONE,
    ACCTD_WAKE3,
    ACCTD_STXOR,
    ACCTD_CLKCTL,
    ACCTD_TMRBIT
  } acctd_kind_e;

endpackage

// ===== design/acctd_dec_if.sv
// decode results passed from the decoder to the executing core
`timescale 1ns/1ps
`default_nettype none
interface acctd_dec_if;
  acctd_pkg::acctd_kind_e kind;
  logic [3:0]             imm;

  modport dec  (output kind, output imm);
  modport core (input  kind, input  imm);
endinterface
`default_nettype wire

// ===== design/acctd_decoder.sv
// combinational opcode decoder for the transfer instructions
`timescale 1ns/1ps
`default_nettype none
module acctd_decoder (
  // instruction word
  input  wire logic [9:0] i_instr,
  // decode result
  acctd_dec_if.dec        dec
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic acctd_pkg::acctd_kind_e decode_kind(
    input logic [9:0] w);
    if (w == acctd_pkg::OPC_WAKE3)
      return acctd_pkg::ACCTD_WAKE3;
    else if (w[acctd_pkg::PFX_LSB +: acctd_pkg::PFX_W]
             == acctd_pkg::PFX_STXOR)
      return acctd_pkg::ACCTD_STXOR;
    else if (w == acctd_pkg::OPC_CLKCTL)
      return acctd_pkg::ACCTD_CLKCTL;
    else if (w == acctd_pkg::OPC_TMRBIT)
      return acctd_pkg::ACCTD_TMRBIT;
    else
      return acctd_pkg::ACCTD_NONE;
  endfunction

  assign dec.kind = decode_kind(i_instr);
  assign dec.imm  = i_instr[acctd_pkg::IMM_LSB +: acctd_pkg::NIB_W];

endmodule
`default_nettype wire

// ===== design/acctd_top.sv
// executes the accumulator-to-register transfer instructions
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Opcode 1000010101 copies the accumulator into wakeup_ctrl_three.
// - Upper six bits 101011 decode store_mem_xor_index, low four are j.
// - store_mem_xor_index writes A to RAM at data_pointer and sets X^=j in the same cycle.
// - load_clock_ctrl copies the accumulator into clock_ctrl_reg.
// - Opcode 1010101010 copies only accumulator bit 0 to the timer bit.
module acctd_top #(
  parameter int ADDR_W = 9
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // instruction and cpu state
  input  wire logic              i_instr_valid,
  input  wire logic [9:0]        i_instr,
  input  wire logic [3:0]        i_acc,
  input  wire logic [3:0]        i_x,
  input  wire logic [ADDR_W-1:0] i_data_pointer,
  // control registers
  output logic      [3:0]        o_wakeup_ctrl_three,
  output logic      [3:0]        o_clock_ctrl_reg,
  output logic                   o_timer_ctrl_bit_reg,
  // ram write
  output logic                   o_ram_we,
  output logic      [ADDR_W-1:0] o_ram_addr,
  output logic      [3:0]        o_ram_wdata,
  // x register update
  output logic                   o_x_we,
  output logic      [3:0]        o_x_value,
  // sequencing
  output logic                   o_done,
  output logic                   o_carry_flag_we,
  output logic                   o_skip
);

  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
    $error("acctd_top: ADDR_W out of range");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  acctd_dec_if dec_if ();

  acctd_decoder u_dec (
    .i_instr (i_instr),
    .dec     (dec_if.dec)
  );

  wire logic hit_wake3;
  wire logic hit_stxor;
  wire logic hit_clkctl;
  wire logic hit_tmrbit;
  wire logic hit_any;

  assign hit_wake3  = i_instr_valid
                      && dec_if.kind == acctd_pkg::ACCTD_WAKE3;
  assign hit_stxor  = i_instr_valid
                      && dec_if.kind == acctd_pkg::ACCTD_STXOR;
  assign hit_clkctl = i_instr_valid
                      && dec_if.kind == acctd_pkg::ACCTD_CLKCTL;
  assign hit_tmrbit = i_instr_valid
                      && dec_if.kind == acctd_pkg::ACCTD_TMRBIT;
  assign hit_any    = hit_wake3 | hit_stxor | hit_clkctl | hit_tmrbit;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  logic [3:0]      wake3_r,  wake3_nxt;
  logic [3:0]      clkctl_r, clkctl_nxt;
  logic            tmrbit_r, tmrbit_nxt;
  logic            ram_we_r;
  logic [ADDR_W-1:0] ram_addr_r;
  logic [3:0]      ram_wdata_r;
  logic            x_we_r;
  logic [3:0]      x_value_r;
  logic            done_r;
  logic            carry_we_r;
  logic            skip_r;

  assign wake3_nxt  = hit_wake3  ? i_acc : wake3_r;
  assign clkctl_nxt = hit_clkctl ? i_acc : clkctl_r;
  assign tmrbit_nxt = hit_tmrbit ? i_acc[acctd_pkg::ACC_BIT0]
                                 : tmrbit_r;

  wire logic [3:0] x_xor;
  assign x_xor = i_x ^ dec_if.imm;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wake3_r  <= acctd_pkg::RST_NIB;
      clkctl_r <= acctd_pkg::RST_NIB;
      tmrbit_r <= acctd_pkg::RST_BIT;
    end else begin
      wake3_r  <= wake3_nxt;
      clkctl_r <= clkctl_nxt;
      tmrbit_r <= tmrbit_nxt;
    end
  end

  // memory store and x update issue together in one cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ram_we_r    <= acctd_pkg::RST_BIT;
      ram_addr_r  <= '0;
      ram_wdata_r <= acctd_pkg::RST_NIB;
      x_we_r      <= acctd_pkg::RST_BIT;
      x_value_r   <= acctd_pkg::RST_NIB;
    end else begin
      ram_we_r <= hit_stxor;
      x_we_r   <= hit_stxor;
      if (hit_stxor) begin
        ram_addr_r  <= i_data_pointer;
        ram_wdata_r <= i_acc;
        x_value_r   <= x_xor;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      done_r     <= acctd_pkg::RST_BIT;
      carry_we_r <= acctd_pkg::RST_BIT;
      skip_r     <= acctd_pkg::RST_BIT;
    end else begin
      done_r     <= hit_any;
      carry_we_r <= acctd_pkg::RST_BIT;
      skip_r     <= acctd_pkg::RST_BIT;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_wakeup_ctrl_three  = wake3_r;
  assign o_clock_ctrl_reg     = clkctl_r;
  assign o_timer_ctrl_bit_reg = tmrbit_r;
  assign o_ram_we             = ram_we_r;
  assign o_ram_addr           = ram_addr_r;
  assign o_ram_wdata          = ram_wdata_r;
  assign o_x_we               = x_we_r;
  assign o_x_value            = x_value_r;
  assign o_done               = done_r;
  // carry and skip are never raised by these instructions
  assign o_carry_flag_we      = carry_we_r;
  assign o_skip               = skip_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // decode from the raw word, independent of the decoder
  wire logic                      want_wake3;
  wire logic                      want_stxor;
  wire logic                      want_clkctl;
  wire logic                      want_tmrbit;
  wire logic                      want_any;
  wire logic [acctd_pkg::NIB_W-1:0] want_imm;

  assign want_wake3  = i_instr_valid && i_instr == acctd_pkg::OPC_WAKE3;
  assign want_stxor  = i_instr_valid
                       && i_instr[acctd_pkg::PFX_LSB +: acctd_pkg::PFX_W]
                          == acctd_pkg::PFX_STXOR;
  assign want_clkctl = i_instr_valid && i_instr == acctd_pkg::OPC_CLKCTL;
  assign want_tmrbit = i_instr_valid && i_instr == acctd_pkg::OPC_TMRBIT;
  assign want_any    = want_wake3 | want_stxor | want_clkctl | want_tmrbit;
  assign want_imm    = i_instr[acctd_pkg::IMM_LSB +: acctd_pkg::NIB_W];

  sequence s_stxor_issue;
    want_stxor;
  endsequence

  sequence s_stxor_effect;
    o_ram_we && o_x_we && o_done;
  endsequence

  a_wake3_load: assert property (
    want_wake3 |=> o_wakeup_ctrl_three == $past(i_acc))
    else $error("wakeup_ctrl_three not loaded from accumulator");

  a_wake3_hold: assert property (
    !want_wake3 |=> $stable(o_wakeup_ctrl_three))
    else $error("wakeup_ctrl_three changed without its instruction");

  a_stxor_decode: assert property (
    s_stxor_issue |=> s_stxor_effect)
    else $error("store_mem_xor_index not decoded");

  a_stxor_data: assert property (
    s_stxor_issue |=> o_ram_wdata == $past(i_acc)
      && o_ram_addr == $past(i_data_pointer)
      && o_x_value == $past(i_x ^ want_imm))
    else $error("store or x xor value wrong");

  a_store_hold: assert property (
    !want_stxor |=> $stable(o_ram_addr) && $stable(o_ram_wdata)
      && $stable(o_x_value))
    else $error("store outputs changed without a store");

  a_clkctl_load: assert property (
    want_clkctl |=> o_clock_ctrl_reg == $past(i_acc))
    else $error("clock_ctrl_reg not loaded from accumulator");

  a_clkctl_hold: assert property (
    !want_clkctl |=> $stable(o_clock_ctrl_reg))
    else $error("clock_ctrl_reg changed without its instruction");

  a_tmrbit_load: assert property (
    want_tmrbit
    |=> o_timer_ctrl_bit_reg == $past(i_acc[acctd_pkg::ACC_BIT0]))
    else $error("timer bit not loaded from accumulator bit 0");

  a_tmrbit_hold: assert property (
    !want_tmrbit |=> $stable(o_timer_ctrl_bit_reg))
    else $error("timer bit changed without its instruction");

  a_one_cycle: assert property (
    want_any |=> o_done)
    else $error("transfer not finished in one cycle");

  a_refused_quiet: assert property (
    !want_any |=> !o_done && !o_ram_we && !o_x_we)
    else $error("done or strobe without a decoded transfer");

  a_no_flags: assert property (
    !o_carry_flag_we && !o_skip)
    else $error("carry or skip raised");

endmodule
`default_nettype wire

// ===== tb/tb_acctd_top.sv
// self-checking bench for the accumulator transfer decode block
`timescale 1ns/1ps
`default_nettype none
module tb_acctd_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk_sys = 1'b0;
  logic       resetn  = 1'b0;
  logic       valid   = 1'b0;
  logic [9:0] instr   = 10'h000;
  logic [3:0] acc     = 4'h0;
  logic [3:0] x       = 4'h0;
  logic [8:0] dptr    = 9'h000;
  logic [3:0] wk, ck, wd, xv;
  logic [8:0] ad;
  logic       tb, rwe, xwe, dn, cwe, skp;
  // expected state
  logic [3:0] e_wk, e_ck, e_wd, e_xv;
  logic [8:0] e_ad;
  logic       e_tb, e_st, e_dn;
  int         miscompares = 0;
  int         n_compared  = 0;
  int         cycles      = 0;

  acctd_top #(.ADDR_W(9)) dut (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_instr_valid(valid),
    .i_instr(instr), .i_acc(acc), .i_x(x), .i_data_pointer(dptr),
    .o_wakeup_ctrl_three(wk), .o_clock_ctrl_reg(ck),
    .o_timer_ctrl_bit_reg(tb), .o_ram_we(rwe), .o_ram_addr(ad),
    .o_ram_wdata(wd), .o_x_we(xwe), .o_x_value(xv), .o_done(dn),
    .o_carry_flag_we(cwe), .o_skip(skp));

  always #10 clk_sys = ~clk_sys;

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic clr_exp();
    {e_wk, e_ck, e_wd, e_xv, e_ad, e_tb, e_st, e_dn} = '0;
  endtask

  task automatic chk_all();
    chk("wake3", {5'h0, wk}, {5'h0, e_wk});
    chk("clkctl", {5'h0, ck}, {5'h0, e_ck});
    chk("tmrbit", {8'h0, tb}, {8'h0, e_tb});
    chk("ram_we", {8'h0, rwe}, {8'h0, e_st});
    chk("ram_addr", ad, e_ad);
    chk("ram_wdata", {5'h0, wd}, {5'h0, e_wd});
    chk("x_we", {8'h0, xwe}, {8'h0, e_st});
    chk("x_value", {5'h0, xv}, {5'h0, e_xv});
    chk("done", {8'h0, dn}, {8'h0, e_dn});
    chk("carry_we", {8'h0, cwe}, 9'h000);
    chk("skip", {8'h0, skp}, 9'h000);
  endtask

  // one instruction word, result checked half a cycle after it is taken
  task automatic op(input logic [9:0] i, input logic [3:0] a,
                    input logic [3:0] xi, input logic [8:0] d);
    logic st;
    st = (i[9:4] === acctd_pkg::PFX_STXOR);
    @(posedge clk_sys);
    valid <= 1'b1;
    instr <= i;
    acc   <= a;
    x     <= xi;
    dptr  <= d;
    @(posedge clk_sys);
    valid <= 1'b0;
    if (i === acctd_pkg::OPC_WAKE3) e_wk = a;
    if (i === acctd_pkg::OPC_CLKCTL) e_ck = a;
    if (i === acctd_pkg::OPC_TMRBIT) e_tb = a[0];
    if (st) begin
      e_ad = d;
      e_wd = a;
      e_xv = xi ^ i[3:0];
    end
    e_st = st;
    e_dn = st || i === acctd_pkg::OPC_WAKE3 ||
           i === acctd_pkg::OPC_CLKCTL || i === acctd_pkg::OPC_TMRBIT;
    @(negedge clk_sys);
    chk_all();
  endtask

  // valid low with a live opcode must be ignored
  task automatic idle();
    @(posedge clk_sys);
    valid <= 1'b0;
    instr <= acctd_pkg::OPC_WAKE3;
    acc   <= 4'hF;
    @(posedge clk_sys);
    e_st = 1'b0;
    e_dn = 1'b0;
    @(negedge clk_sys);
    chk_all();
  endtask

  // two loads back to back, each checked in its own cycle
  task automatic pair(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk_sys);
    valid <= 1'b1;
    instr <= acctd_pkg::OPC_WAKE3;
    acc   <= a;
    @(posedge clk_sys);
    instr <= acctd_pkg::OPC_CLKCTL;
    acc   <= b;
    e_wk = a;
    e_st = 1'b0;
    e_dn = 1'b1;
    @(negedge clk_sys);
    chk_all();
    @(posedge clk_sys);
    valid <= 1'b0;
    e_ck = b;
    @(negedge clk_sys);
    chk_all();
  endtask

  initial begin
    clr_exp();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_all();
    @(posedge clk_sys);
    resetn <= 1'b1;
    op(acctd_pkg::OPC_WAKE3, 4'hA, 4'h0, 9'h000);
    op(acctd_pkg::OPC_CLKCTL, 4'h5, 4'h0, 9'h000);
    op(acctd_pkg::OPC_TMRBIT, 4'hE, 4'h0, 9'h000);
    op(acctd_pkg::OPC_TMRBIT, 4'h1, 4'h0, 9'h000);
    for (int j = 0; j < 16; j++)
      op({acctd_pkg::PFX_STXOR, 4'(j)}, 4'(j) ^ 4'h6, 4'hC,
         9'h0F0 + 9'(j));
    op({acctd_pkg::PFX_STXOR, 4'hF}, 4'hF, 4'hF, 9'h1FF);
    op(acctd_pkg::OPC_WAKE3, 4'h0, 4'h3, 9'h055);
    op(10'h217, 4'h7, 4'h1, 9'h001);
    op(10'h214, 4'h7, 4'h1, 9'h001);
    op(10'h2AB, 4'h7, 4'h1, 9'h001);
    op(10'h3B5, 4'h7, 4'h1, 9'h001);
    idle();
    op(acctd_pkg::OPC_CLKCTL, 4'hF, 4'h0, 9'h000);
    idle();
    pair(4'h3, 4'hC);
    @(posedge clk_sys);
    resetn <= 1'b0;
    @(negedge clk_sys);
    clr_exp();
    chk_all();
    @(posedge clk_sys);
    resetn <= 1'b1;
    op(acctd_pkg::OPC_CLKCTL, 4'h9, 4'h0, 9'h000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
